// [hdl/swd_pkg.sv]
// constants for the supervisor, watchdog and control register block
package swd_pkg;

    localparam int unsigned CLK_KHZ       = 125000;
    localparam int unsigned POR_DELAY_MS  = 200;
    localparam int unsigned WD_LONG_MS    = 1400;
    localparam int unsigned WD_MID_MS     = 600;
    localparam int unsigned WD_SHORT_MS   = 200;
    localparam int unsigned NV_WRITE_MS   = 10;

    localparam int unsigned POR_CYC       = POR_DELAY_MS * CLK_KHZ;
    localparam int unsigned WD_LONG_CYC   = WD_LONG_MS * CLK_KHZ;
    localparam int unsigned WD_MID_CYC    = WD_MID_MS * CLK_KHZ;
    localparam int unsigned WD_SHORT_CYC  = WD_SHORT_MS * CLK_KHZ;
    localparam int unsigned NV_WRITE_CYC  = NV_WRITE_MS * CLK_KHZ;

    localparam int          CNT_W         = 28;
    localparam int          NV_CNT_W      = 21;

    localparam logic [15:0] CTRL_ADDR     = 16'hffff;

    // control register field positions
    localparam int          HPE_BIT       = 7;
    localparam int          WDH_BIT       = 6;
    localparam int          WDL_BIT       = 5;
    localparam int          BPM_BIT       = 4;
    localparam int          BPL_BIT       = 3;
    localparam int          RWL_BIT       = 2;
    localparam int          WL_BIT        = 1;
    localparam int          BPH_BIT       = 0;

    // volatile latch command bytes and the trip-point program byte
    localparam logic [7:0]  SET_WL_BYTE   = 8'h02;
    localparam logic [7:0]  SET_RWL_BYTE  = 8'h06;
    localparam logic [7:0]  CLR_WL_BYTE   = 8'h00;
    localparam logic [7:0]  VTRIP_BYTE    = 8'h00;

    // nonvolatile reset (factory) values and the watchdog-off period code
    localparam logic [1:0]  WD_RESET      = 2'h3;
    localparam logic [1:0]  WD_OFF        = 2'h3;
    localparam logic [2:0]  BP_RESET      = 3'h0;
    localparam logic        HPE_RESET     = 1'b0;

    // protected address bounds
    localparam logic [13:0] Q4_BASE       = 14'h3000;
    localparam logic [13:0] HALF_BASE     = 14'h2000;
    localparam logic [13:0] P1_END        = 14'h0040;
    localparam logic [13:0] P2_END        = 14'h0080;
    localparam logic [13:0] P4_END        = 14'h0100;
    localparam logic [13:0] P8_END        = 14'h0200;

endpackage

// [hdl/swd_sync.sv]
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module swd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] stage1_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= '0;
            dout      <= '0;
        end else if (ce) begin
            stage1_ff <= din;
            dout      <= stage1_ff;
        end
    end
endmodule // swd_sync
`default_nettype wire

// [hdl/swd_supervisor.sv]
// supervisor: power-on/brown-out reset, watchdog, control register and write gating
`timescale 1ns/1ps
`default_nettype none
module swd_supervisor
    import swd_pkg::*;
#(
    parameter int unsigned POR_CYCLES   = POR_CYC,
    parameter int unsigned WD_LONG_CYC  = swd_pkg::WD_LONG_CYC,
    parameter int unsigned WD_MID_CYC   = swd_pkg::WD_MID_CYC,
    parameter int unsigned WD_SHORT_CYC = swd_pkg::WD_SHORT_CYC,
    parameter int unsigned NV_CYCLES    = NV_WRITE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        scl_pin,
    input  wire logic        sda_pin,
    input  wire logic        vcc_ok_pin,
    input  wire logic        wp_pin,
    input  wire logic        programming_level,
    input  wire logic        wr_strobe,
    input  wire logic        wr_first,
    input  wire logic [15:0] wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        vtrip_cmd,
    output var  logic        sys_reset,
    output var  logic        ack_valid,
    output var  logic        data_ack,
    output var  logic        bus_abort,
    output var  logic        array_wr_go,
    output var  logic        vtrip_prog_go,
    output var  logic        nv_busy,
    output var  logic [7:0]  ctrl_value
);

    typedef struct packed {
        logic [CNT_W-1:0]    por_cnt;
        logic [CNT_W-1:0]    wd_cnt;
        logic [NV_CNT_W-1:0] nv_cnt;
        logic                sysrst;
        logic                wl;
        logic                rwl;
        logic                hpe;
        logic [1:0]          wd;
        logic [2:0]          bp;
        logic                pend_val;
        logic [7:0]          pend_byte;
        logic                pend_arr;
        logic                pend_vtrip;
        logic                nv_busy;
        logic                ack_valid;
        logic                data_ack;
        logic                bus_abort;
        logic                array_go;
        logic                vtrip_go;
        logic                sda_d;
        logic [7:0]          ctrl;
    } swd_state_t;

    localparam logic [CNT_W-1:0]    POR_END   = CNT_W'(POR_CYCLES);
    localparam logic [CNT_W-1:0]    WDL_END   = CNT_W'(WD_LONG_CYC - 1);
    localparam logic [CNT_W-1:0]    WDM_END   = CNT_W'(WD_MID_CYC - 1);
    localparam logic [CNT_W-1:0]    WDS_END   = CNT_W'(WD_SHORT_CYC - 1);
    localparam logic [NV_CNT_W-1:0] NV_END    = NV_CNT_W'(NV_CYCLES - 1);

    swd_state_t state_ff;
    swd_state_t nxt_state;

    logic [4:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       vcc_s;
    logic       wp_s;
    logic       vp_s;
    logic       start_cond;
    logic       stop_cond;
    logic [CNT_W-1:0] wd_end;
    logic       wd_expire;

    swd_sync #(
        .W    (5)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  ({scl_pin, sda_pin, vcc_ok_pin, wp_pin, programming_level}),
        .dout (pins_s)
    );

    assign {scl_s, sda_s, vcc_s, wp_s, vp_s} = pins_s;

    assign start_cond = scl_s & state_ff.sda_d & ~sda_s;
    assign stop_cond  = scl_s & ~state_ff.sda_d & sda_s;

    // timeout selection by period bits
    always_comb begin
        case (state_ff.wd)
            2'h0:    wd_end = WDL_END;
            2'h1:    wd_end = WDM_END;
            2'h2:    wd_end = WDS_END;
            default: wd_end = WDL_END;
        endcase
    end

    assign wd_expire = (state_ff.wd != WD_OFF) && !state_ff.sysrst && (state_ff.wd_cnt == wd_end);

    // address inside the protected block for the current code
    function automatic logic in_protected(input logic [2:0] bp, input logic [15:0] addr);
        logic [13:0] a;
        a = addr[13:0];
        case (bp)
            3'h1:    in_protected = (a >= Q4_BASE);
            3'h2:    in_protected = (a >= HALF_BASE);
            3'h3:    in_protected = 1'b1;
            3'h4:    in_protected = (a < P1_END);
            3'h5:    in_protected = (a < P2_END);
            3'h6:    in_protected = (a < P4_END);
            3'h7:    in_protected = (a < P8_END);
            default: in_protected = 1'b0;
        endcase
    endfunction

    always_comb begin
        nxt_state           = state_ff;
        nxt_state.sda_d     = sda_s;
        nxt_state.ack_valid = 1'b0;
        nxt_state.data_ack  = 1'b0;
        nxt_state.bus_abort = 1'b0;
        nxt_state.array_go  = 1'b0;
        nxt_state.vtrip_go  = 1'b0;

        // supply supervision
        if (!vcc_s) begin
            nxt_state.por_cnt = '0;
        end else if (state_ff.por_cnt != POR_END) begin
            nxt_state.por_cnt = state_ff.por_cnt + 1'b1;
        end

        // watchdog
        if (state_ff.sysrst || start_cond || state_ff.wd == WD_OFF) begin
            nxt_state.wd_cnt = '0;
        end else begin
            nxt_state.wd_cnt = state_ff.wd_cnt + 1'b1;
        end
        if (wd_expire) begin
            nxt_state.por_cnt = '0;
        end

        nxt_state.sysrst    = (nxt_state.por_cnt != POR_END);
        nxt_state.bus_abort = nxt_state.sysrst & ~state_ff.sysrst;

        // a new start ends whatever write was pending
        if (start_cond || nxt_state.sysrst) begin
            nxt_state.pend_val   = 1'b0;
            nxt_state.pend_arr   = 1'b0;
            nxt_state.pend_vtrip = 1'b0;
        end

        // nonvolatile register cycle, runs on through reset
        if (state_ff.nv_busy) begin
            if (state_ff.nv_cnt == NV_END) begin
                nxt_state.nv_busy = 1'b0;
                // new period counts from zero, never past a shorter end
                nxt_state.wd_cnt  = '0;
                if (!wp_s) begin
                    nxt_state.wd = {state_ff.pend_byte[WDH_BIT], state_ff.pend_byte[WDL_BIT]};
                end
                if (!(wp_s && state_ff.hpe)) begin
                    nxt_state.hpe = state_ff.pend_byte[HPE_BIT];
                    nxt_state.bp  = {state_ff.pend_byte[BPH_BIT], state_ff.pend_byte[BPM_BIT],
                                     state_ff.pend_byte[BPL_BIT]};
                end
                nxt_state.rwl = state_ff.pend_byte[RWL_BIT];
            end else begin
                nxt_state.nv_cnt = state_ff.nv_cnt + 1'b1;
            end
        end

        // data byte from the bus engine
        if (wr_strobe && !state_ff.sysrst) begin
            nxt_state.ack_valid = 1'b1;
            if (state_ff.nv_busy) begin
                nxt_state.data_ack = 1'b0;
            end else if (!state_ff.wl) begin
                nxt_state.data_ack = 1'b0;
            end else if (wr_addr == CTRL_ADDR) begin
                if (!wr_first) begin
                    nxt_state.pend_val = 1'b0;
                end else if (state_ff.rwl) begin
                    nxt_state.pend_val  = 1'b1;
                    nxt_state.pend_byte = wr_data;
                    nxt_state.data_ack  = 1'b1;
                end else if (wr_data == SET_RWL_BYTE) begin
                    nxt_state.rwl      = 1'b1;
                    nxt_state.data_ack = 1'b1;
                end else if (wr_data == SET_WL_BYTE) begin
                    nxt_state.data_ack = 1'b1;
                end else if (wr_data == CLR_WL_BYTE) begin
                    nxt_state.wl       = 1'b0;
                    nxt_state.data_ack = 1'b1;
                end
            end else if (vtrip_cmd) begin
                if (wr_first && wr_data == VTRIP_BYTE && vp_s) begin
                    nxt_state.pend_vtrip = 1'b1;
                    nxt_state.data_ack   = 1'b1;
                end
            end else if (in_protected(state_ff.bp, wr_addr)) begin
                nxt_state.rwl = 1'b0;
            end else begin
                nxt_state.pend_arr = 1'b1;
                nxt_state.data_ack = 1'b1;
            end
        end

        // setting the write latch needs it clear beforehand, so handle it apart
        if (wr_strobe && !state_ff.sysrst && !state_ff.nv_busy && !state_ff.wl && wr_first
            && wr_addr == CTRL_ADDR && wr_data == SET_WL_BYTE) begin
            nxt_state.wl       = 1'b1;
            nxt_state.data_ack = 1'b1;
        end

        // stop launches what the transaction asked for
        if (stop_cond && !state_ff.sysrst) begin
            if (state_ff.pend_val) begin
                nxt_state.nv_busy = 1'b1;
                nxt_state.nv_cnt  = '0;
            end
            nxt_state.array_go   = state_ff.pend_arr;
            nxt_state.vtrip_go   = state_ff.pend_vtrip;
            nxt_state.pend_val   = 1'b0;
            nxt_state.pend_arr   = 1'b0;
            nxt_state.pend_vtrip = 1'b0;
        end

        nxt_state.ctrl = {nxt_state.hpe, nxt_state.wd, nxt_state.bp[1], nxt_state.bp[0],
                          nxt_state.rwl, nxt_state.wl, nxt_state.bp[2]};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff      <= '0;
            state_ff.wd   <= WD_RESET;
            state_ff.bp   <= BP_RESET;
            state_ff.hpe  <= HPE_RESET;
            state_ff.sysrst <= 1'b1;
            state_ff.ctrl <= {HPE_RESET, WD_RESET, BP_RESET[1], BP_RESET[0], 1'b0, 1'b0, BP_RESET[2]};
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign sys_reset     = state_ff.sysrst;
    assign ack_valid     = state_ff.ack_valid;
    assign data_ack      = state_ff.data_ack;
    assign bus_abort     = state_ff.bus_abort;
    assign array_wr_go   = state_ff.array_go;
    assign vtrip_prog_go = state_ff.vtrip_go;
    assign nv_busy       = state_ff.nv_busy;
    assign ctrl_value    = state_ff.ctrl;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence supply_low_s;
        !vcc_s;
    endsequence

    sequence reset_seen_s;
        ##1 sys_reset;
    endsequence

    brownout_reset_a: assert property (supply_low_s |-> reset_seen_s)
        else $error("reset not asserted after supply loss");

    release_delay_a: assert property ($fell(sys_reset) |-> $past(state_ff.por_cnt) == POR_END - 1'b1)
        else $error("reset released before full delay");

    wdog_expiry_a: assert property (wd_expire |=> sys_reset && state_ff.por_cnt == '0)
        else $error("watchdog expiry did not assert reset");

    wdog_off_a: assert property (state_ff.wd == WD_OFF |-> state_ff.wd_cnt == '0)
        else $error("disabled watchdog is counting");

    abort_pulse_a: assert property ($rose(sys_reset) |-> bus_abort ##1 !bus_abort)
        else $error("abort pulse missing on reset entry");

    no_ack_reset_a: assert property (sys_reset |-> ##1 !ack_valid)
        else $error("byte answered while reset active");

    no_go_reset_a: assert property (sys_reset |=> !array_wr_go && !vtrip_prog_go && !$rose(nv_busy))
        else $error("write launched during reset");

    nv_finish_a: assert property (nv_busy && sys_reset && state_ff.nv_cnt != NV_END |=> nv_busy)
        else $error("nonvolatile cycle cut by reset");

    wl_gate_a: assert property (wr_strobe && !state_ff.wl && !(wr_first && wr_addr == CTRL_ADDR
                                && wr_data == SET_WL_BYTE) |=> !data_ack)
        else $error("byte acknowledged with write latch clear");

    second_byte_a: assert property (wr_strobe && !wr_first && wr_addr == CTRL_ADDR |=> !data_ack)
        else $error("second control byte acknowledged");

    prot_write_a: assert property (wr_strobe && state_ff.wl && !state_ff.nv_busy && !state_ff.sysrst
                                   && wr_addr != CTRL_ADDR && !vtrip_cmd && in_protected(state_ff.bp, wr_addr)
                                   |=> !data_ack && !state_ff.pend_arr)
        else $error("protected location accepted");

    wd_lock_a: assert property (nv_busy && state_ff.nv_cnt == NV_END && wp_s |=> $stable(state_ff.wd))
        else $error("period bits changed while locked");

    rwl_keep_a: assert property (nv_busy && state_ff.nv_cnt == NV_END
                                 |=> state_ff.rwl == $past(state_ff.pend_byte[RWL_BIT]))
        else $error("register latch wrong after store");

endmodule // swd_supervisor
`default_nettype wire

// [tb/swd_host_model.sv]
// host model: 2-wire master framing plus decoded byte requests
`timescale 1ns/1ps
`default_nettype none
module swd_host_model (
    input  wire logic        clk,
    input  wire logic        ack_valid,
    input  wire logic        data_ack,
    output var  logic        scl,
    output var  logic        sda,
    output var  logic        wr_strobe,
    output var  logic        wr_first,
    output var  logic [15:0] wr_addr,
    output var  logic [7:0]  wr_data,
    output var  logic        vtrip_cmd
);
    logic    run;
    realtime t_start;
    logic    link_clk = 1'h1;

    assign scl = link_clk;

    initial begin
        run       = 1'h0;
        t_start   = 0.0;
        sda       = 1'h1;
        wr_strobe = 1'h0;
        wr_first  = 1'h0;
        wr_addr   = 16'h0000;
        wr_data   = 8'h00;
        vtrip_cmd = 1'h0;
    end

    // link clock, parked high between frames
    always begin
        #62.5;
        if (run) link_clk = ~link_clk;
    end

    task automatic put(input logic [15:0] a, input logic [7:0] d, input logic f, output logic [1:0] r);
        @(posedge clk) #1;
        wr_strobe = 1'h1;
        wr_first  = f;
        wr_addr   = a;
        wr_data   = d;
        @(posedge clk) #1;
        r         = {ack_valid, ack_valid & data_ack};
        wr_strobe = 1'h0;
        wr_addr   = ~a;
        wr_data   = ~d;
    endtask

    task automatic xfer(input logic [15:0] a, input logic [7:0] d, input logic two, input logic vt,
                        output logic [1:0] r1, output logic [1:0] r2);
        @(posedge clk) #1;
        vtrip_cmd = vt;
        sda       = 1'h0;
        t_start   = $realtime;
        repeat (6) @(posedge clk);
        run = 1'h1;
        put(a, d, 1'h1, r1);
        r2 = 2'h2;
        if (two) put(a, ~d, 1'h0, r2);
        wait (scl == 1'h0);
        @(posedge scl);
        run = 1'h0;
        @(posedge clk) #1;
        sda = 1'h1;
        repeat (6) @(posedge clk);
        #1;
        vtrip_cmd = 1'h0;
    endtask
endmodule // swd_host_model
`default_nettype wire

// [tb/supervisor_wdog_ctrl_reg_tb.sv]
// self-checking bench for the supervisor block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module supervisor_wdog_ctrl_reg_tb
    import swd_pkg::*;
;
    localparam int POR = 50;
    localparam int WDS = 100;
    localparam int NVC = 20;

    // m = {wp, threshold}, x = {ack_valid, ack, nv, go, vtrip go}
    typedef struct packed {
        logic [1:0]  m;
        logic [15:0] a;
        logic [7:0]  d;
        logic        two;
        logic [4:0]  x;
        logic [7:0]  ctrl;
    } swd_row_t;

    swd_row_t rows [22] = '{
        '{2'h0, CTRL_ADDR, 8'h06, 1'h0, 5'h10, 8'h60},
        '{2'h0, CTRL_ADDR, 8'h02, 1'h0, 5'h18, 8'h62},
        '{2'h0, CTRL_ADDR, 8'h00, 1'h0, 5'h18, 8'h60},
        '{2'h0, 16'h0100,  8'h11, 1'h0, 5'h10, 8'h60},
        '{2'h0, CTRL_ADDR, 8'h02, 1'h0, 5'h18, 8'h62},
        '{2'h0, CTRL_ADDR, 8'h06, 1'h0, 5'h18, 8'h66},
        '{2'h0, CTRL_ADDR, 8'h60, 1'h1, 5'h18, 8'h66},
        '{2'h0, CTRL_ADDR, 8'h77, 1'h0, 5'h1c, 8'h77},
        '{2'h0, 16'h0080,  8'h11, 1'h0, 5'h10, 8'h73},
        '{2'h0, 16'h0100,  8'h11, 1'h0, 5'h1a, 8'h73},
        '{2'h0, CTRL_ADDR, 8'h06, 1'h0, 5'h18, 8'h77},
        '{2'h0, CTRL_ADDR, 8'h02, 1'h0, 5'h1c, 8'h02},
        '{2'h2, CTRL_ADDR, 8'h06, 1'h0, 5'h18, 8'h06},
        '{2'h2, CTRL_ADDR, 8'h66, 1'h0, 5'h1c, 8'h06},
        '{2'h0, CTRL_ADDR, 8'h86, 1'h0, 5'h1c, 8'h86},
        '{2'h2, CTRL_ADDR, 8'h7f, 1'h0, 5'h1c, 8'h86},
        '{2'h1, 16'h1234,  8'h00, 1'h0, 5'h19, 8'h86},
        '{2'h0, CTRL_ADDR, 8'h2e, 1'h0, 5'h1c, 8'h2e},
        '{2'h0, 16'h3000,  8'h11, 1'h0, 5'h10, 8'h2a},
        '{2'h0, 16'h2fff,  8'h11, 1'h0, 5'h1a, 8'h2a},
        '{2'h0, CTRL_ADDR, 8'h06, 1'h0, 5'h18, 8'h2e},
        '{2'h0, CTRL_ADDR, 8'h46, 1'h0, 5'h1c, 8'h46}
    };

    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        vcc_ok_pin = 1'h1;
    logic        wp_pin = 1'h0;
    logic        programming_level = 1'h0;
    logic        scl;
    logic        sda;
    logic        wr_strobe;
    logic        wr_first;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        vtrip_cmd;
    logic        sys_reset;
    logic        ack_valid;
    logic        data_ack;
    logic        bus_abort;
    logic        array_wr_go;
    logic        vtrip_prog_go;
    logic        nv_busy;
    logic [7:0]  ctrl_value;
    logic [2:0]  seen = 3'h0;
    logic        clr_seen = 1'h0;
    logic        ce = 1'h1;
    logic [1:0]  r1;
    logic [1:0]  r2;
    int          n;
    int          n_fail = 0;
    int          check_count = 0;
    int          cyc = 0;

    always #4 clk = ~clk;

    swd_supervisor #(
        .POR_CYCLES  (POR),
        .WD_LONG_CYC (400),
        .WD_MID_CYC  (200),
        .WD_SHORT_CYC(WDS),
        .NV_CYCLES   (NVC)
    ) swd_supervisor_i (
        .clk              (clk),
        .rst              (rst),
        .ce               (ce),
        .scl_pin          (scl),
        .sda_pin          (sda),
        .vcc_ok_pin       (vcc_ok_pin),
        .wp_pin           (wp_pin),
        .programming_level(programming_level),
        .wr_strobe        (wr_strobe),
        .wr_first         (wr_first),
        .wr_addr          (wr_addr),
        .wr_data          (wr_data),
        .vtrip_cmd        (vtrip_cmd),
        .sys_reset        (sys_reset),
        .ack_valid        (ack_valid),
        .data_ack         (data_ack),
        .bus_abort        (bus_abort),
        .array_wr_go      (array_wr_go),
        .vtrip_prog_go    (vtrip_prog_go),
        .nv_busy          (nv_busy),
        .ctrl_value       (ctrl_value)
    );

    swd_host_model swd_host_model_i (
        .clk      (clk),
        .ack_valid(ack_valid),
        .data_ack (data_ack),
        .scl      (scl),
        .sda      (sda),
        .wr_strobe(wr_strobe),
        .wr_first (wr_first),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .vtrip_cmd(vtrip_cmd)
    );

    always @(posedge clk) begin
        seen <= (clr_seen ? 3'h0 : seen) | {nv_busy === 1'h1, array_wr_go === 1'h1, vtrip_prog_go === 1'h1};
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wait_rst(input logic lvl);
        n = 0;
        while (sys_reset !== lvl && n < 300) begin
            @(posedge clk) #1;
            n++;
        end
    endtask

    task automatic wait_idle();
        repeat (NVC + 10) if (nv_busy === 1'h1) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'h0;
        `CHK(sys_reset, 1'h1)
        `CHK(ctrl_value, 8'h60)
        wait_rst(1'h0);
        `CHK(n inside {[POR:POR + 6]}, 1'h1)
        repeat (500) @(posedge clk);
        #1;
        `CHK(sys_reset, 1'h0)
        foreach (rows[i]) begin
            wp_pin = rows[i].m[1];
            programming_level = rows[i].m[0];
            clr_seen = 1'h1;
            @(posedge clk) #1;
            clr_seen = 1'h0;
            repeat (2) @(posedge clk);
            swd_host_model_i.xfer(rows[i].a, rows[i].d, rows[i].two, rows[i].m[0], r1, r2);
            wait_idle();
            `CHK(r1, rows[i].x[4:3])
            if (rows[i].two) `CHK(r2, 2'h2)
            `CHK(seen, rows[i].x[2:0])
            `CHK(ctrl_value, rows[i].ctrl)
        end
        // watchdog expiry after the last start
        swd_host_model_i.xfer(16'h3fff, 8'h00, 1'h0, 1'h0, r1, r2);
        wait_rst(1'h1);
        `CHK(bus_abort, 1'h1)
        `CHK(int'(($realtime - swd_host_model_i.t_start) / 8.0) inside {[WDS + 1:WDS + 8]}, 1'h1)
        clr_seen = 1'h1;
        @(posedge clk) #1;
        clr_seen = 1'h0;
        swd_host_model_i.xfer(CTRL_ADDR, 8'h66, 1'h0, 1'h0, r1, r2);
        `CHK(r1[1], 1'h0)
        `CHK(seen[2], 1'h0)
        wait_rst(1'h0);
        swd_host_model_i.xfer(CTRL_ADDR, 8'h66, 1'h0, 1'h0, r1, r2);
        wait_idle();
        `CHK(ctrl_value, 8'h66)
        // brown-out in the middle of a register store
        swd_host_model_i.xfer(CTRL_ADDR, 8'h6e, 1'h0, 1'h0, r1, r2);
        vcc_ok_pin = 1'h0;
        wait_rst(1'h1);
        `CHK(n inside {[1:5]}, 1'h1)
        `CHK(bus_abort, 1'h1)
        `CHK(nv_busy, 1'h1)
        wait_idle();
        `CHK(ctrl_value, 8'h6e)
        vcc_ok_pin = 1'h1;
        wait_rst(1'h0);
        `CHK(n inside {[POR:POR + 6]}, 1'h1)
        // frozen block: a supply dip while ce is low goes unseen
        ce = 1'h0;
        vcc_ok_pin = 1'h0;
        repeat (10) @(posedge clk);
        #1;
        `CHK(sys_reset, 1'h0)
        vcc_ok_pin = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        ce = 1'h1;
        repeat (60) @(posedge clk);
        #1;
        `CHK(sys_reset, 1'h0)
        `CHK(ctrl_value, 8'h6e)
        conclude();
    end
endmodule // supervisor_wdog_ctrl_reg_tb
`default_nettype wire
